// >>> acis_pkg.sv
package acis_pkg;
	// Register byte offsets
	localparam logic [3:0] ACIS_OFF_CLK = 4'h0;
	localparam logic [3:0] ACIS_OFF_MUX = 4'h4;
	localparam logic [3:0] ACIS_OFF_SCAN = 4'h8;
	localparam logic [3:0] ACIS_OFF_CTRL = 4'hC;
	// Clock register fields
	localparam int ACIS_SRC_BIT = 15;
	localparam int ACIS_AUTO_SAMPLE_TIME_LSB = 8;
	localparam int ACIS_AUTO_SAMPLE_TIME_MSB = 12;
	localparam int ACIS_DIV_LSB = 0;
	localparam int ACIS_DIV_MSB = 7;
	localparam logic [31:0] ACIS_CLK_MASK = 32'h00009FFF;
	// Input select fields
	localparam int ACIS_SA_LSB = 16;
	localparam int ACIS_SA_MSB = 19;
	localparam int ACIS_NA_BIT = 23;
	localparam int ACIS_SB_LSB = 24;
	localparam int ACIS_SB_MSB = 27;
	localparam int ACIS_NB_BIT = 31;
	localparam logic [31:0] ACIS_MUX_MASK = 32'h8F8F0000;
	localparam logic [31:0] ACIS_SCAN_MASK = 32'h0000FFFF;
	// Control register: trigger source, scan enable, alternate mode, start, busy
	localparam int ACIS_TRIG_LSB = 0;
	localparam int ACIS_TRIG_MSB = 2;
	localparam int ACIS_SCANEN_BIT = 4;
	localparam int ACIS_ALT_BIT = 5;
	localparam int ACIS_START_BIT = 8;
	localparam int ACIS_BUSY_BIT = 16;
	localparam logic [31:0] ACIS_CTRL_MASK = 32'h00000037;
	localparam logic [2:0] ACIS_TRIG_AUTO = 3'h7;
	localparam logic [31:0] ACIS_RESET_VAL = 32'h00000000;
	// Positive input codes
	localparam logic [3:0] ACIS_IN_MAX_PIN = 4'hC;
	localparam logic [3:0] ACIS_IN_TEMP = 4'hD;
	localparam logic [3:0] ACIS_IN_IREF = 4'hE;
	localparam logic [3:0] ACIS_IN_OPEN = 4'hF;
	// Route codes driven to the analog side
	localparam logic [4:0] ACIS_RT_LOWREF = 5'h10;
	localparam logic [4:0] ACIS_RT_TEMP = 5'h11;
	localparam logic [4:0] ACIS_RT_IREF = 5'h12;
	localparam logic [4:0] ACIS_RT_OPEN = 5'h13;
	localparam logic [4:0] ACIS_RT_CHARGE_TIME_UNIT = 5'h14;
	localparam logic [4:0] ACIS_RT_GND = 5'h15;
	localparam int ACIS_MASK_CHARGE_TIME_UNIT = 13;
	localparam int ACIS_MASK_IREF = 14;
	localparam int ACIS_MASK_GND = 15;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ACIS_IDLE = 2'b00,
		ACIS_SAMPLE = 2'b01,
		ACIS_CONVERT = 2'b11
	} acis_state_t;
endpackage : acis_pkg

// >>> acis_clkdiv.sv
`timescale 1ns/10ps
// Converter clock tick generator: one tick per converter clock period
module acis_clkdiv (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic use_rc,
	input wire logic rc_clk,
	input wire logic [7:0] divider,
	output logic tick
);
	logic [8:0] cnt_reg;
	logic rc_d_reg;
	logic [8:0] limit;
	logic bus_tick;
	logic rc_tick;
	// Period = 2 * (divider + 1) bus periods
	assign limit = {divider, 1'b1};
	assign bus_tick = (cnt_reg == limit);
	// RC oscillator is sampled as a synchronous level; one tick per rising edge
	assign rc_tick = rc_clk & ~rc_d_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 9'h000;
			rc_d_reg <= 1'b0;
			tick <= 1'b0;
		end else begin
			rc_d_reg <= rc_clk;
			cnt_reg <= (bus_tick || use_rc) ? 9'h000 : cnt_reg + 9'h001;
			tick <= use_rc ? rc_tick : bus_tick;
		end
	end
endmodule : acis_clkdiv

// >>> acis_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Bit 15 picks RC oscillator, else bus
// - Bus clock period is 2*(divider+1) periods
// - Divider ignored when RC oscillator chosen
// - Sample time is field value in periods
// - Sample time used only in counter trigger
// - Sample A positive code routes pins, sensors
// - Sample B positive uses same encoding
// - Sample A negative: input 1 or low ref
// - Sample B negative: input 1 or low ref
// - Scan mask bit includes or skips input
// - Mask bits map pins, charge, reference, ground
// - Missing pins convert the low reference
// - Unimplemented bits read back as zero
// - Trigger code 111 is automatic counter
// - Scan enable picks mask or fixed input
// - Alternate mode: A first, then B/A
module acis_ctrl
	import acis_pkg::*;
#(
	parameter int NUM_PINS = 13
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rc_osc,
	input wire logic ext_end_sample,
	input wire logic conv_done,
	output logic sampling,
	output logic conv_start,
	output logic [4:0] pos_route,
	output logic neg_is_input1
);
	import acis_pkg::*;

	if (NUM_PINS < 1 || NUM_PINS > 13) begin : g_bad_pins
		$error("NUM_PINS must be 1 to 13");
	end

	logic [31:0] clk_reg;
	logic [31:0] mux_reg;
	logic [31:0] scan_reg;
	logic [31:0] ctrl_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	acis_state_t state_reg;
	logic [4:0] samp_cnt_reg;
	logic use_b_reg;
	logic [3:0] scan_pos_reg;
	logic [4:0] route_reg;
	logic neg_reg;

	// Write channel capture
	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] wr_bytes;
	logic wr_clk;
	logic wr_mux;
	logic wr_scan;
	logic wr_ctrl;
	logic wr_bad;
	logic start_req;

	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_addr = aw_take ? s_axi_awaddr : aw_addr_reg;
	assign wr_data = w_take ? s_axi_wdata : w_data_reg;
	assign wr_strb = w_take ? s_axi_wstrb : w_strb_reg;
	assign wr_fire = (aw_take || aw_got_reg) && (w_take || w_got_reg) && !s_axi_bvalid;
	assign wr_bytes = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign wr_clk = wr_fire && (wr_addr == ACIS_OFF_CLK);
	assign wr_mux = wr_fire && (wr_addr == ACIS_OFF_MUX);
	assign wr_scan = wr_fire && (wr_addr == ACIS_OFF_SCAN);
	assign wr_ctrl = wr_fire && (wr_addr == ACIS_OFF_CTRL);
	assign wr_bad = !(wr_addr == ACIS_OFF_CLK || wr_addr == ACIS_OFF_MUX || wr_addr == ACIS_OFF_SCAN
		|| wr_addr == ACIS_OFF_CTRL);
	assign start_req = wr_ctrl && wr_strb[1] && wr_data[ACIS_START_BIT];

	// Merge with byte enables; unimplemented bits never store
	function automatic logic [31:0] acis_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] be, input logic [31:0] msk);
		acis_merge = ((old & ~be) | (nw & be)) & msk;
	endfunction : acis_merge

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else begin
			s_axi_awready <= !aw_got_reg && !aw_take && !wr_fire && !s_axi_bvalid;
			s_axi_wready <= !w_got_reg && !w_take && !wr_fire && !s_axi_bvalid;
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_bad ? AXI_SLVERR : AXI_OKAY;
			end else begin
				aw_got_reg <= aw_got_reg || aw_take;
				w_got_reg <= w_got_reg || w_take;
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_reg <= ACIS_RESET_VAL;
			mux_reg <= ACIS_RESET_VAL;
			scan_reg <= ACIS_RESET_VAL;
			ctrl_reg <= ACIS_RESET_VAL;
		end else begin
			if (wr_clk) begin
				clk_reg <= acis_merge(clk_reg, wr_data, wr_bytes, ACIS_CLK_MASK);
			end
			if (wr_mux) begin
				mux_reg <= acis_merge(mux_reg, wr_data, wr_bytes, ACIS_MUX_MASK);
			end
			if (wr_scan) begin
				scan_reg <= acis_merge(scan_reg, wr_data, wr_bytes, ACIS_SCAN_MASK);
			end
			if (wr_ctrl) begin
				ctrl_reg <= acis_merge(ctrl_reg, wr_data, wr_bytes, ACIS_CTRL_MASK);
			end
		end
	end

	// Read channel
	logic [31:0] rd_word;
	logic rd_bad;
	logic busy;
	assign busy = (state_reg != ACIS_IDLE);
	assign rd_bad = !(s_axi_araddr == ACIS_OFF_CLK || s_axi_araddr == ACIS_OFF_MUX
		|| s_axi_araddr == ACIS_OFF_SCAN || s_axi_araddr == ACIS_OFF_CTRL);
	assign rd_word = (s_axi_araddr == ACIS_OFF_CLK) ? clk_reg :
		(s_axi_araddr == ACIS_OFF_MUX) ? mux_reg :
		(s_axi_araddr == ACIS_OFF_SCAN) ? scan_reg :
		(s_axi_araddr == ACIS_OFF_CTRL) ? (ctrl_reg | ({31'h00000000, busy} << ACIS_BUSY_BIT)) :
		32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_bad ? AXI_SLVERR : AXI_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Converter clock
	logic tad_tick;
	acis_clkdiv u_clkdiv (
		.aclk(aclk),
		.aresetn(aresetn),
		.use_rc(clk_reg[ACIS_SRC_BIT]),
		.rc_clk(rc_osc),
		.divider(clk_reg[ACIS_DIV_MSB:ACIS_DIV_LSB]),
		.tick(tad_tick)
	);

	// Sequencing
	logic [2:0] trig_sel;
	logic auto_mode;
	logic [4:0] samp_time;
	logic samp_end;
	logic scan_on;
	logic alt_on;
	assign trig_sel = ctrl_reg[ACIS_TRIG_MSB:ACIS_TRIG_LSB];
	assign auto_mode = (trig_sel == ACIS_TRIG_AUTO);
	assign samp_time = clk_reg[ACIS_AUTO_SAMPLE_TIME_MSB:ACIS_AUTO_SAMPLE_TIME_LSB];
	// Zero sample time is disallowed; treated as one period rather than hanging
	assign samp_end = auto_mode ? (tad_tick && (samp_cnt_reg + 5'h01 >= samp_time)) : ext_end_sample;
	assign scan_on = ctrl_reg[ACIS_SCANEN_BIT];
	assign alt_on = ctrl_reg[ACIS_ALT_BIT];

	// A change of setup restarts the sequence at the next start; plain restarts keep stepping
	logic [31:0] ctrl_new;
	logic seq_restart;
	logic seq_fresh_reg;
	logic start_fresh;
	logic seq_fresh_next;
	assign ctrl_new = acis_merge(ctrl_reg, wr_data, wr_bytes, ACIS_CTRL_MASK);
	assign seq_restart = wr_mux || wr_scan || (wr_ctrl && (ctrl_new[ACIS_SCANEN_BIT] != scan_on
		|| ctrl_new[ACIS_ALT_BIT] != alt_on));
	assign start_fresh = seq_fresh_reg || seq_restart;
	assign seq_fresh_next = (start_req && state_reg == ACIS_IDLE) ? 1'b0 : start_fresh;

	// Next selected scan input above the current one, wrapping to the lowest
	logic [15:0] scan_mask;
	logic [15:0] above;
	logic [3:0] first_sel;
	logic [3:0] next_above;
	logic any_above;
	assign scan_mask = scan_reg[15:0];
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_above
			assign above[gi] = scan_mask[gi] && (gi > scan_pos_reg);
		end
	endgenerate
	always_comb begin
		first_sel = 4'h0;
		next_above = 4'h0;
		any_above = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (scan_mask[i]) begin
				first_sel = 4'(i);
			end
			if (above[i]) begin
				next_above = 4'(i);
				any_above = 1'b1;
			end
		end
	end

	// Map a fixed positive code to a route
	function automatic logic [4:0] acis_pos_route(input logic [3:0] code);
		if (code <= ACIS_IN_MAX_PIN) begin
			acis_pos_route = (int'(code) < NUM_PINS) ? {1'b0, code} : ACIS_RT_LOWREF;
		end else if (code == ACIS_IN_TEMP) begin
			acis_pos_route = ACIS_RT_TEMP;
		end else if (code == ACIS_IN_IREF) begin
			acis_pos_route = ACIS_RT_IREF;
		end else begin
			acis_pos_route = ACIS_RT_OPEN;
		end
	endfunction : acis_pos_route

	// Map a scan position to a route
	function automatic logic [4:0] acis_scan_route(input logic [3:0] pos);
		if (int'(pos) == ACIS_MASK_CHARGE_TIME_UNIT) begin
			acis_scan_route = ACIS_RT_CHARGE_TIME_UNIT;
		end else if (int'(pos) == ACIS_MASK_IREF) begin
			acis_scan_route = ACIS_RT_IREF;
		end else if (int'(pos) == ACIS_MASK_GND) begin
			acis_scan_route = ACIS_RT_GND;
		end else begin
			acis_scan_route = (int'(pos) < NUM_PINS) ? {1'b0, pos} : ACIS_RT_LOWREF;
		end
	endfunction : acis_scan_route

	logic [3:0] pos_code;
	logic neg_sel;
	logic [4:0] route_next;
	assign pos_code = use_b_reg ? mux_reg[ACIS_SB_MSB:ACIS_SB_LSB] : mux_reg[ACIS_SA_MSB:ACIS_SA_LSB];
	assign neg_sel = use_b_reg ? mux_reg[ACIS_NB_BIT] : mux_reg[ACIS_NA_BIT];
	assign route_next = scan_on ? acis_scan_route(scan_pos_reg) : acis_pos_route(pos_code);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ACIS_IDLE;
			samp_cnt_reg <= 5'h00;
			use_b_reg <= 1'b0;
			scan_pos_reg <= 4'h0;
			route_reg <= ACIS_RT_LOWREF;
			neg_reg <= 1'b0;
			sampling <= 1'b0;
			conv_start <= 1'b0;
			seq_fresh_reg <= 1'b1;
		end else begin
			conv_start <= 1'b0;
			seq_fresh_reg <= seq_fresh_next;
			unique case (state_reg)
				ACIS_IDLE: begin
					if (start_req) begin
						state_reg <= ACIS_SAMPLE;
						samp_cnt_reg <= 5'h00;
						sampling <= 1'b1;
						// Restart only after reset or a setup change, else alternation and scan could never advance
						if (start_fresh) begin
							use_b_reg <= 1'b0;
							scan_pos_reg <= first_sel;
						end
					end
				end
				ACIS_SAMPLE: begin
					route_reg <= route_next;
					neg_reg <= scan_on ? 1'b0 : neg_sel;
					if (tad_tick) begin
						samp_cnt_reg <= samp_cnt_reg + 5'h01;
					end
					if (samp_end) begin
						state_reg <= ACIS_CONVERT;
						sampling <= 1'b0;
						conv_start <= 1'b1;
					end
				end
				ACIS_CONVERT: begin
					if (conv_done) begin
						state_reg <= ACIS_IDLE;
						use_b_reg <= alt_on ? !use_b_reg : 1'b0;
						scan_pos_reg <= any_above ? next_above : first_sel;
					end
				end
				default: begin
					state_reg <= ACIS_IDLE;
				end
			endcase
		end
	end

	assign pos_route = route_reg;
	assign neg_is_input1 = neg_reg;
endmodule : acis_ctrl

// >>> acis_ctrl_asserts.sv
`timescale 1ns/10ps
module acis_ctrl_chk
	import acis_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic sampling,
	input wire logic conv_start,
	input wire logic [4:0] pos_route
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	a_start_ends: assert property (conv_start |-> !sampling && $past(sampling))
		else $error("conversion start without end of sampling");
	a_route_held: assert property (!sampling && !$past(sampling) |-> $stable(pos_route))
		else $error("route changed outside sampling");
	a_route_legal: assert property (pos_route < 5'h0D || (pos_route >= ACIS_RT_LOWREF && pos_route <= ACIS_RT_GND))
		else $error("route code out of range");
	a_reset_out: assert property ($rose(aresetn) |-> pos_route == ACIS_RT_LOWREF && !sampling && !conv_start)
		else $error("outputs wrong after reset");
endmodule : acis_ctrl_chk

bind acis_ctrl acis_ctrl_chk chk (.*);

// >>> acis_core_model.sv
`timescale 1ns/10ps
module acis_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic conv_start,
	output logic conv_done
);
	// Short and long conversions alternate so both answer speeds are seen
	logic [3:0] cnt_reg;
	logic slow_reg;
	always_ff @(posedge aclk) begin
		conv_done <= 1'h0;
		if (!aresetn) begin
			cnt_reg <= 4'h0;
			slow_reg <= 1'h0;
		end else if (conv_start) begin
			cnt_reg <= slow_reg ? 4'h9 : 4'h2;
			slow_reg <= !slow_reg;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
			conv_done <= (cnt_reg == 4'h1);
		end
	end
endmodule : acis_core_model

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import acis_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, rc_osc = 1'h0, ext_end_sample = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic conv_done, sampling, conv_start, neg_is_input1, neg_seen;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp_seen;
	logic [4:0] pos_route, route_seen;
	int err_total = 0, checked = 0, len_reg = 0, len_seen = 0, done_n = 0;
	// Fewer pins than codes, so absent inputs are reachable
	acis_ctrl #(.NUM_PINS(10)) uut (.*);
	acis_core_model core (.*);
	always #2 aclk = ~aclk;
	always begin
		repeat (4) @(posedge aclk);
		rc_osc <= ~rc_osc;
	end
	always @(posedge aclk) begin
		len_reg <= sampling ? len_reg + 1 : 0;
		if (conv_start) begin
			len_seen <= len_reg;
			route_seen <= pos_route;
			neg_seen <= neg_is_input1;
		end
		if (conv_done) done_n <= done_n + 1;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	task automatic tmo(input bit bad);
		if (bad) begin
			err_total++;
			wrap_up();
		end
	endtask : tmo
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		bit aw, w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (n = 0; n < 200 && !(aw && w); n++) begin
			@(posedge aclk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= s_axi_awvalid & !s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid & !s_axi_wready;
		end
		@(posedge aclk);
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_bvalid && n < 400);
		resp_seen = s_axi_bresp;
		s_axi_bready <= 1'h0;
		tmo(n >= 400);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 200);
		s_axi_arvalid <= 1'h0;
		@(posedge aclk);
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_rvalid && n < 400);
		d = s_axi_rdata;
		resp_seen = s_axi_rresp;
		s_axi_rready <= 1'h0;
		tmo(n >= 400);
	endtask : rd
	task automatic conv(input logic [31:0] ctrl, input int ext);
		int n;
		int d0;
		d0 = done_n;
		wr(ACIS_OFF_CTRL, ctrl | 32'h00000100);
		if (ext > 0) begin
			repeat (ext) @(posedge aclk);
			ext_end_sample <= 1'h1;
		end
		for (n = 0; n < 300 && done_n == d0; n++) @(posedge aclk);
		ext_end_sample <= 1'h0;
		tmo(n >= 300);
	endtask : conv
	initial begin
		logic [31:0] v;
		int p, e;
		static logic [31:0] msk [3] = '{ACIS_CLK_MASK, ACIS_MUX_MASK, ACIS_SCAN_MASK};
		static int sd [3] = '{1, 4, 31};
		static int dv [3] = '{0, 2, 1};
		static logic [3:0] cd [4] = '{4'h9, 4'hB, 4'hE, 4'hF};
		static logic [4:0] ex [4] = '{5'h09, ACIS_RT_LOWREF, ACIS_RT_IREF, ACIS_RT_OPEN};
		static logic [4:0] sc [5] = '{5'h02, ACIS_RT_LOWREF, ACIS_RT_CHARGE_TIME_UNIT, ACIS_RT_GND, 5'h02};
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			rd(4'(i * 4), v);
			chk("reset value", 32'h0, v);
			chk("read response", {30'h0, AXI_OKAY}, {30'h0, resp_seen});
		end
		for (int i = 0; i < 3; i++) begin
			wr(4'(i * 4), 32'hFFFFFFFF);
			chk("write response", {30'h0, AXI_OKAY}, {30'h0, resp_seen});
			rd(4'(i * 4), v);
			chk("writable bits", msk[i], v);
		end
		wr(ACIS_OFF_CTRL, 32'hFFFFFEFF);
		rd(ACIS_OFF_CTRL, v);
		chk("control bits", 32'h00000037, v);
		$display("test registers done");
		wr(ACIS_OFF_SCAN, 32'h0);
		wr(ACIS_OFF_MUX, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(ACIS_OFF_CLK, {19'h0, 5'(sd[i]), 8'(dv[i])});
			conv(32'h7, 0);
			p = 2 * (dv[i] + 1);
			e = (sd[i] == 0) ? 1 : sd[i];
			chk("sample length", 1, len_seen > (e - 1) * p && len_seen <= e * p + 2);
		end
		// Divider at maximum would give a far longer window if it were not ignored
		wr(ACIS_OFF_CLK, 32'h000082FF);
		conv(32'h7, 0);
		chk("rc sample length", 1, len_seen > 8 && len_seen <= 18);
		wr(ACIS_OFF_CLK, 32'h00000100);
		conv(32'h0, 40);
		chk("external end", 1, len_seen >= 40);
		$display("test timing done");
		foreach (cd[i]) begin
			wr(ACIS_OFF_MUX, {12'h0, cd[i], 16'h0});
			conv(32'h7, 0);
			chk("fixed route", ex[i], route_seen);
		end
		wr(ACIS_OFF_MUX, 32'h0D850000);
		for (int i = 0; i < 3; i++) begin
			conv(32'h27, 0);
			chk("alt route", (i == 1) ? ACIS_RT_TEMP : 5'h05, route_seen);
			chk("alt negative", i != 1, neg_seen);
		end
		$display("test mux done");
		wr(ACIS_OFF_SCAN, 32'h0000A804);
		foreach (sc[i]) begin
			conv(32'h17, 0);
			chk("scan route", sc[i], route_seen);
			chk("scan negative", 32'h0, neg_seen);
		end
		$display("test scan done");
		wrap_up();
	end
endmodule : tb_top
